// ==== pkg/wwdrt_pkg.sv ====
// constants, field layout and decode helpers of the watchdog and reset timing block
package wwdrt_pkg;
  // clock and base tick
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned TICK_NS = 1000;
  localparam int unsigned TICK_CYC = CLK_HZ / 1_000_000 * TICK_NS / 1000;
  localparam int unsigned TW = 22;
  // times in microseconds
  localparam int unsigned T_SEL_RST_MAX_US = 200;
  localparam int unsigned T_RST0_US = 20000;
  localparam int unsigned T_RST1_US = 10000;
  localparam int unsigned T_RST2_US = 3600;
  localparam int unsigned T_RST3_US = 1000;
  localparam int unsigned T_EXT_RST_US = 18;
  localparam int unsigned T_LIMP_US = 117000;
  localparam int unsigned T_WAKE_US = 50;
  localparam int unsigned T_NV_DLY_US = 900000;
  localparam int unsigned T_NV_PROG_US = 12000;
  localparam int unsigned T_CAN_ACT_US = 320;
  localparam int unsigned US_PER_MS = 1000;
  // filter limits in ticks, one extra tick covers the phase of the first tick
  localparam int unsigned FLT_EXT_TICKS = T_EXT_RST_US * 1000 / TICK_NS + 1;
  localparam int unsigned FLT_WAKE_TICKS = T_WAKE_US * 1000 / TICK_NS + 1;
  // register offsets
  localparam logic [7:0] A_MODE = 8'h00;
  localparam logic [7:0] A_WDCTL = 8'h01;
  localparam logic [7:0] A_STAT = 8'h02;
  localparam logic [7:0] A_MASK = 8'h03;
  localparam logic [7:0] A_STATE = 8'h04;
  localparam logic [7:0] A_CMD = 8'h05;
  localparam logic [7:0] A_CRC = 8'h75;
  // fields
  localparam int WD_NWP_LSB = 0;
  localparam int WD_WIN_BIT = 3;
  localparam int WD_RLC_LSB = 4;
  localparam logic [2:0] MODE_NORMAL = 3'h7;
  localparam logic [2:0] MODE_RST = 3'h0;
  localparam logic [5:0] WDCTL_RST = 6'h04;
  localparam int ST_EARLY = 0;
  localparam int ST_OVF = 1;
  localparam int ST_EXT = 2;
  localparam int ST_WAKE = 3;
  localparam int ST_NVDONE = 4;
  localparam int NST = 5;
  localparam int CMD_RESTORE = 0;
  localparam int CMD_CLR_LIMP = 1;

  typedef enum logic [1:0] {S_RUN = 2'b01, S_RESET = 2'b10} wwdrt_wd_t;
  typedef enum logic [2:0] {N_IDLE = 3'b001, N_WAIT = 3'b010, N_PROG = 3'b100} wwdrt_nv_t;

  // nominal watchdog period in ms per code
  function automatic logic [12:0] nwp_ms(input logic [2:0] c);
    case (c)
      3'h0: return 13'h0008;
      3'h1: return 13'h0010;
      3'h2: return 13'h0020;
      3'h3: return 13'h0040;
      3'h4: return 13'h0080;
      3'h5: return 13'h0100;
      3'h6: return 13'h0400;
      default: return 13'h1000;
    endcase
  endfunction
endpackage

// ==== design/wwdrt_tmr.sv ====
// one-shot tick timer: runs len+1 ticks after start, pulses done at the end
`timescale 1ns/10ps
`default_nettype none
module wwdrt_tmr (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic tick_i,
  input wire logic start_i,
  input wire logic abort_i,
  input wire logic [wwdrt_pkg::TW-1:0] len_i,
  output logic busy_o,
  output logic done_o
);
  localparam int TW = wwdrt_pkg::TW;
  logic [TW-1:0] cnt;
  logic done;

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      cnt <= '0;
      done <= 1'b0;
    end
    else
    begin
      done <= tick_i && !abort_i && !start_i && cnt == TW'(1);
      if (abort_i)
        cnt <= '0;
      else if (start_i)
        cnt <= TW'(len_i + TW'(1));
      else if (tick_i && cnt != '0)
        cnt <= TW'(cnt - TW'(1));
    end
  end

  assign busy_o = cnt != '0;
  assign done_o = done;
endmodule
`default_nettype wire

// ==== design/wwdrt_top.sv ====
// window watchdog, reset pulse, fail flag, config store and transceiver enable timing
// Operation
// R1: early window trigger pulls reset low promptly
// R2: trigger before first limit forces system reset
// R3: trigger between limits restarts period, no reset
// R4: no trigger by second limit: overflow reset
// R5: nominal period chosen by software period code
// R6: wait 0.9-1.1 s before factory restore
// R7: correct CRC at 075h programs store 10-14ms
// R8: Normal mode enables transceiver within 320 us
// R9: reset width per length code; input filtered
// R10: fail flag after 117-145 ms; wake filtered
//
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module wwdrt_top #(
  parameter int P_TICK_CYC = wwdrt_pkg::TICK_CYC,
  parameter int P_MS_US = wwdrt_pkg::US_PER_MS,
  parameter int P_RST0_US = wwdrt_pkg::T_RST0_US,
  parameter int P_RST1_US = wwdrt_pkg::T_RST1_US,
  parameter int P_RST2_US = wwdrt_pkg::T_RST2_US,
  parameter int P_RST3_US = wwdrt_pkg::T_RST3_US,
  parameter int P_LIMP_US = wwdrt_pkg::T_LIMP_US,
  parameter int P_NV_DLY_US = wwdrt_pkg::T_NV_DLY_US,
  parameter int P_NV_PROG_US = wwdrt_pkg::T_NV_PROG_US
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic serial_select_n_i,
  input wire logic wd_trig_i,
  input wire logic ext_rst_n_i,
  input wire logic wake_i,
  input wire logic [7:0] nv_crc_i,
  output logic reset_out_n_o,
  output logic limp_o,
  output logic can_en_o,
  output logic nv_prog_o,
  output logic nv_restore_o,
  output logic irq_o
);
  localparam int TW = wwdrt_pkg::TW;
  localparam int NST = wwdrt_pkg::NST;

  // tick divider
  logic [7:0] div;
  wire tick = div == 8'(P_TICK_CYC - 1);
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i || tick)
      div <= '0;
    else
      div <= 8'(div + 8'h01);
  end

  // registers
  logic [2:0] mode_control_field;
  logic [5:0] wdctl;
  logic [NST-1:0] stat;
  logic [NST-1:0] mask;
  logic [7:0] rdata;
  wire wr_mode = reg_wr_i && reg_addr_i == wwdrt_pkg::A_MODE;
  wire wr_wdctl = reg_wr_i && reg_addr_i == wwdrt_pkg::A_WDCTL;
  wire wr_stat = reg_wr_i && reg_addr_i == wwdrt_pkg::A_STAT;
  wire wr_mask = reg_wr_i && reg_addr_i == wwdrt_pkg::A_MASK;
  wire wr_cmd = reg_wr_i && reg_addr_i == wwdrt_pkg::A_CMD;
  wire wr_crc = reg_wr_i && reg_addr_i == wwdrt_pkg::A_CRC;
  wire [2:0] nominal_period_code = wdctl[wwdrt_pkg::WD_NWP_LSB +: 3];
  wire win_en = wdctl[wwdrt_pkg::WD_WIN_BIT];
  wire [1:0] reset_length_code = wdctl[wwdrt_pkg::WD_RLC_LSB +: 2];

  // reset width per code, scaled by the ticks per millisecond
  function automatic logic [TW-1:0] rst_len(input logic [1:0] c);
    case (c)
      2'h0: return TW'(P_RST0_US * P_MS_US / wwdrt_pkg::US_PER_MS);
      2'h1: return TW'(P_RST1_US * P_MS_US / wwdrt_pkg::US_PER_MS);
      2'h2: return TW'(P_RST2_US * P_MS_US / wwdrt_pkg::US_PER_MS);
      default: return TW'(P_RST3_US * P_MS_US / wwdrt_pkg::US_PER_MS);
    endcase
  endfunction

  // input filters: 0 external reset, 1 wake
  wire [1:0] flt_in = {wake_i, !ext_rst_n_i};
  wire [1:0] flt_evt;
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_flt
      localparam logic [6:0] LIM = 7'(g == 0 ? wwdrt_pkg::FLT_EXT_TICKS : wwdrt_pkg::FLT_WAKE_TICKS);
      logic [6:0] fc;
      always_ff @(posedge sys_clk_i)
      begin
        if (!rst_n_i || !flt_in[g])
          fc <= '0;
        else if (tick && fc != LIM)
          fc <= 7'(fc + 7'h01);
      end
      // R9 R10: pulse accepted only when long enough
      assign flt_evt[g] = tick && flt_in[g] && fc == 7'(LIM - 7'h01);
    end
  endgenerate

  // watchdog
  wwdrt_pkg::wwdrt_wd_t wd_state;
  wwdrt_pkg::wwdrt_wd_t next_wd_state;
  logic [TW-1:0] wd_cnt;
  logic sel_q;
  logic rst_done;
  wire st_run = wd_state == wwdrt_pkg::S_RUN;
  // R5: period from the software code
  wire [TW-1:0] wd_limit = TW'(wwdrt_pkg::nwp_ms(nominal_period_code) * P_MS_US);
  wire [TW-1:0] wd_half = wd_limit >> 1;
  wire sel_rise = serial_select_n_i && !sel_q;
  wire trig = st_run && sel_rise && wd_trig_i;
  // R2: trigger inside the closed half of the window
  wire early_trig = trig && win_en && wd_cnt < wd_half;
  // R3: trigger inside the open half restarts the period
  wire ok_trig = trig && !early_trig;
  // R4: overflow at the full period
  wire wd_ovf = st_run && !trig && wd_cnt >= wd_limit;
  wire ext_evt = st_run && flt_evt[0];
  wire sys_rst_req = early_trig || wd_ovf || ext_evt;

  always_comb
  begin
    next_wd_state = wd_state;
    case (wd_state)
      wwdrt_pkg::S_RUN:
        if (sys_rst_req)
          next_wd_state = wwdrt_pkg::S_RESET;
      wwdrt_pkg::S_RESET:
        if (rst_done)
          next_wd_state = wwdrt_pkg::S_RUN;
      default:
        next_wd_state = wwdrt_pkg::S_RESET;
    endcase
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      wd_state <= wwdrt_pkg::S_RUN;
      sel_q <= 1'b1;
      wd_cnt <= '0;
    end
    else
    begin
      wd_state <= next_wd_state;
      sel_q <= serial_select_n_i;
      if (!st_run || ok_trig)
        wd_cnt <= '0;
      else if (tick && wd_cnt < wd_limit)
        wd_cnt <= TW'(wd_cnt + TW'(1));
    end
  end

  // R1: reset output follows the state flop, low one cycle after the select rise
  assign reset_out_n_o = wd_state != wwdrt_pkg::S_RESET;

  // R9: reset pulse width from the length code
  wwdrt_tmr u_rst_tmr (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .tick_i(tick),
    .start_i(st_run && sys_rst_req),
    .abort_i(1'b0),
    .len_i(rst_len(reset_length_code)),
    .busy_o(),
    .done_o(rst_done)
  );

  // fail flag delay
  logic limp;
  logic limp_done;
  logic limp_busy;
  wire fail_evt = early_trig || wd_ovf;
  wire clr_limp = wr_cmd && reg_wdata_i[wwdrt_pkg::CMD_CLR_LIMP];
  // R10: fail flag raised after the limp delay
  wwdrt_tmr u_limp_tmr (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .tick_i(tick),
    .start_i(fail_evt && !limp && !limp_busy),
    .abort_i(clr_limp),
    .len_i(TW'(P_LIMP_US)),
    .busy_o(limp_busy),
    .done_o(limp_done)
  );
  always_ff @(posedge sys_clk_i)
  begin
    // a finished delay wins over a clear in the same cycle
    if (!rst_n_i)
      limp <= 1'b0;
    else if (limp_done)
      limp <= 1'b1;
    else if (clr_limp)
      limp <= 1'b0;
  end
  assign limp_o = limp;

  // transceiver enable on Normal mode
  logic mode_normal_q;
  logic can_en;
  logic can_done;
  wire mode_normal = mode_control_field == wwdrt_pkg::MODE_NORMAL;
  // R8: enable no later than the activation delay
  wwdrt_tmr u_can_tmr (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .tick_i(tick),
    .start_i(mode_normal && !mode_normal_q),
    .abort_i(!mode_normal),
    // three short: start edge, done flop and enable flop stay inside the limit
    .len_i(TW'(wwdrt_pkg::T_CAN_ACT_US * 1000 / wwdrt_pkg::TICK_NS - 3)),
    .busy_o(),
    .done_o(can_done)
  );
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      mode_normal_q <= 1'b0;
      can_en <= 1'b0;
    end
    else
    begin
      mode_normal_q <= mode_normal;
      can_en <= mode_normal && (can_en || can_done);
    end
  end
  assign can_en_o = can_en;

  // configuration store sequencer
  wwdrt_pkg::wwdrt_nv_t nv_state;
  wwdrt_pkg::wwdrt_nv_t next_nv_state;
  logic nv_done;
  logic nv_restore;
  wire nv_idle = nv_state == wwdrt_pkg::N_IDLE;
  wire restore_go = nv_idle && wr_cmd && reg_wdata_i[wwdrt_pkg::CMD_RESTORE];
  // R7: only a matching CRC at the CRC address starts programming
  wire crc_good = nv_idle && !restore_go && wr_crc && reg_wdata_i == nv_crc_i;
  wire [TW-1:0] nv_len = restore_go ? TW'(P_NV_DLY_US) : TW'(P_NV_PROG_US);
  wire nv_end = nv_done && !nv_idle;

  always_comb
  begin
    next_nv_state = nv_state;
    case (nv_state)
      wwdrt_pkg::N_IDLE:
        if (restore_go)
          next_nv_state = wwdrt_pkg::N_WAIT;
        else if (crc_good)
          next_nv_state = wwdrt_pkg::N_PROG;
      wwdrt_pkg::N_WAIT:
        if (nv_done)
          next_nv_state = wwdrt_pkg::N_IDLE;
      wwdrt_pkg::N_PROG:
        if (nv_done)
          next_nv_state = wwdrt_pkg::N_IDLE;
      default:
        next_nv_state = wwdrt_pkg::N_IDLE;
    endcase
  end

  // R6 R7: one timer for restore delay and programming time
  wwdrt_tmr u_nv_tmr (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .tick_i(tick),
    .start_i(restore_go || crc_good),
    .abort_i(1'b0),
    .len_i(nv_len),
    .busy_o(),
    .done_o(nv_done)
  );
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      nv_state <= wwdrt_pkg::N_IDLE;
      nv_restore <= 1'b0;
    end
    else
    begin
      nv_state <= next_nv_state;
      nv_restore <= nv_done && nv_state == wwdrt_pkg::N_WAIT;
    end
  end
  assign nv_prog_o = nv_state == wwdrt_pkg::N_PROG;
  assign nv_restore_o = nv_restore;

  // status, mask and software registers; a new event wins over its clear
  wire [NST-1:0] events = {nv_end, flt_evt[1], ext_evt, wd_ovf, early_trig};
  wire [NST-1:0] stat_clr = wr_stat ? reg_wdata_i[NST-1:0] : '0;
  wire [7:0] state_view = {3'h0, !nv_idle && !nv_prog_o, nv_prog_o, can_en, limp, !reset_out_n_o};
  wire [7:0] rd_mux = reg_addr_i == wwdrt_pkg::A_MODE ? {5'h00, mode_control_field} :
                      reg_addr_i == wwdrt_pkg::A_WDCTL ? {2'h0, wdctl} :
                      reg_addr_i == wwdrt_pkg::A_STAT ? 8'(stat) :
                      reg_addr_i == wwdrt_pkg::A_MASK ? 8'(mask) :
                      reg_addr_i == wwdrt_pkg::A_STATE ? state_view : 8'h00;
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      mode_control_field <= wwdrt_pkg::MODE_RST;
      wdctl <= wwdrt_pkg::WDCTL_RST;
      stat <= '0;
      mask <= '0;
      rdata <= 8'h00;
    end
    else
    begin
      if (wr_mode)
        mode_control_field <= reg_wdata_i[2:0];
      if (wr_wdctl)
        wdctl <= reg_wdata_i[5:0];
      if (wr_mask)
        mask <= reg_wdata_i[NST-1:0];
      stat <= (stat & ~stat_clr) | events;
      rdata <= reg_rd_i ? rd_mux : 8'h00;
    end
  end
  assign reg_rdata_o = rdata;
  assign irq_o = |(stat & mask);

  // checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_early;
    early_trig;
  endsequence
  sequence s_ovf;
    wd_ovf;
  endsequence
  sequence s_low8;
    !reset_out_n_o [*8];
  endsequence

  chk_early_rst: assert property (s_early |=> !reset_out_n_o) // R1
    else $error("early trigger did not pull reset low");
  chk_rst_cause: assert property ($fell(reset_out_n_o) |-> $past(sys_rst_req)) // R2
    else $error("reset without a cause");
  chk_window_ok: assert property (ok_trig |=> wd_cnt == '0 && reset_out_n_o) // R3
    else $error("window trigger did not restart period");
  chk_ovf_reset: assert property (s_ovf |=> s_low8) // R4
    else $error("overflow did not reset");
  chk_period_bound: assert property (st_run && $stable(wdctl) |-> wd_cnt <= wd_limit) // R5
    else $error("watchdog count past period");
  chk_restore_wait: assert property (restore_go |=> !nv_restore_o [*8]) // R6
    else $error("restore came too soon");
  chk_prog_time: assert property (crc_good |=> nv_prog_o [*8]) // R7
    else $error("programming ended too soon");
  chk_can_delay: assert property ($rose(mode_normal) |=> !can_en_o [*8]) // R8
    else $error("transceiver enabled too soon");
  chk_rst_width: assert property ($fell(reset_out_n_o) |-> s_low8) // R9
    else $error("reset pulse too short");
  chk_limp_delay: assert property (fail_evt && !limp_o && !limp_busy |=> !limp_o [*8]) // R10
    else $error("fail flag too soon");
endmodule
`default_nettype wire

// ==== bench/wwdrt_host.sv ====
// host model: drives select frames that carry a watchdog trigger
`timescale 1ns/10ps
`default_nettype none
module wwdrt_host (
  input wire logic sys_clk_i,
  input wire logic go_i,
  input wire logic trig_i,
  input wire logic slow_i,
  output logic serial_select_n_o,
  output logic wd_trig_o,
  output logic busy_o
);
  logic [2:0] cnt = 3'h0;
  logic trig_q = 1'b0;
  always_ff @(posedge sys_clk_i)
  begin
    if (go_i && cnt == 3'h0)
    begin
      cnt <= slow_i ? 3'h7 : 3'h5;
      trig_q <= trig_i;
    end
    else if (cnt != 3'h0)
    begin
      cnt <= cnt - 3'h1;
    end
  end
  // qualifier held one cycle past the select rise
  assign serial_select_n_o = (cnt < 3'h2);
  // released qualifier shows the inverse of its last value
  assign wd_trig_o = (cnt != 3'h0) ? trig_q : ~trig_q;
  assign busy_o = (cnt != 3'h0);
endmodule
`default_nettype wire

// ==== bench/tb_window_watchdog_reset_timing.sv ====
// self-checking bench of the watchdog and reset timing block
`timescale 1ns/10ps
`default_nettype none
`define check(got, exp) \
  begin \
    compares++; \
    if ((got) !== (exp)) \
    begin \
      miscompares++; \
      $display("wrong value at %0t: %0h vs %0h", $time, (got), (exp)); \
    end \
  end
module tb_window_watchdog_reset_timing;
  logic sys_clk_i;
  logic rst_n_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic ext_rst_n_i = 1'b1;
  logic wake_i = 1'b0;
  logic [7:0] nv_crc_i = 8'h5a;
  logic go = 1'b0;
  logic trig = 1'b1;
  logic slow = 1'b0;
  logic [7:0] reg_rdata_o;
  logic serial_select_n, wd_trig, hbusy;
  logic reset_out_n_o, limp_o, can_en_o, nv_prog_o, nv_restore_o, irq_o;
  int miscompares = 0;
  int compares = 0;
  int n;
  // minimum reset widths in ticks at 10 ticks per ms
  int rw[4] = '{200, 100, 36, 10};

  // reset widths keep their defaults and scale with the ticks per millisecond
  wwdrt_top #(.P_TICK_CYC(1), .P_MS_US(10), .P_LIMP_US(40), .P_NV_DLY_US(60), .P_NV_PROG_US(30)) dut_u (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .serial_select_n_i(serial_select_n), .wd_trig_i(wd_trig),
    .ext_rst_n_i(ext_rst_n_i), .wake_i(wake_i), .nv_crc_i(nv_crc_i), .reset_out_n_o(reset_out_n_o),
    .limp_o(limp_o), .can_en_o(can_en_o), .nv_prog_o(nv_prog_o), .nv_restore_o(nv_restore_o), .irq_o(irq_o));
  wwdrt_host host_u (.sys_clk_i(sys_clk_i), .go_i(go), .trig_i(trig), .slow_i(slow),
    .serial_select_n_o(serial_select_n), .wd_trig_o(wd_trig), .busy_o(hbusy));

  initial
  begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end

  function automatic logic pick(input int s);
    case (s)
      0: return reset_out_n_o;
      1: return limp_o;
      2: return can_en_o;
      3: return nv_prog_o;
      default: return nv_restore_o;
    endcase
  endfunction

  task automatic tick();
    @(posedge sys_clk_i);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    tick();
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    tick();
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    tick();
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    tick();
    reg_rd_i <= 1'b0;
    `check(reg_rdata_o, e)
  endtask

  // counts cycles until the picked output shows v, at most lim
  task automatic wait_lvl(input int s, input logic v, input int lim, output int k);
    k = 0;
    while (k < lim && pick(s) !== v)
    begin
      tick();
      k++;
    end
  endtask

  task automatic trigger(input logic sl);
    int k;
    k = 0;
    tick();
    go <= 1'b1;
    slow <= sl;
    tick();
    go <= 1'b0;
    while (hbusy && k < 12)
    begin
      tick();
      k++;
    end
  endtask

  task automatic print_verdict();
    if (miscompares == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge sys_clk_i);
    miscompares++;
    print_verdict();
  end

  initial
  begin
    repeat (16) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    rd(wwdrt_pkg::A_STAT, 8'h00);
    rd(wwdrt_pkg::A_WDCTL, 8'h04);
    rd(8'h10, 8'h00);
    wr(wwdrt_pkg::A_WDCTL, 8'h08);
    trigger(1'b0);
    wait_lvl(0, 1'b0, 200, n);
    `check(n < 200, 1'b1)
    rd(wwdrt_pkg::A_STAT, 8'h01);
    `check(irq_o, 1'b0)
    wr(wwdrt_pkg::A_MASK, 8'h01);
    tick();
    `check(irq_o, 1'b1)
    wr(wwdrt_pkg::A_STAT, 8'h01);
    tick();
    `check(irq_o, 1'b0)
    wait_lvl(0, 1'b1, 300, n);
    for (int c = 0; c < 4; c++)
    begin
      wr(wwdrt_pkg::A_WDCTL, {2'h0, c[1:0], 4'h8});
      trigger(1'b0);
      wait_lvl(0, 1'b0, 200, n);
      `check(n < 200, 1'b1)
      wait_lvl(0, 1'b1, 300, n);
      `check(n inside {[rw[c] + 1:rw[c] + 2]}, 1'b1)
    end
    // fail flag: cleared by command, then timed from an early reset
    wr(wwdrt_pkg::A_CMD, 8'h02);
    wait_lvl(1, 1'b0, 3, n);
    `check(n < 3, 1'b1)
    wr(wwdrt_pkg::A_WDCTL, 8'h38);
    trigger(1'b0);
    wait_lvl(0, 1'b0, 200, n);
    wait_lvl(1, 1'b1, 100, n);
    `check(n inside {[40:44]}, 1'b1)
    // timeout mode restart aligns the period before the window checks
    wr(wwdrt_pkg::A_WDCTL, 8'h30);
    trigger(1'b0);
    wr(wwdrt_pkg::A_WDCTL, 8'h38);
    repeat (3)
    begin
      wait_lvl(0, 1'b0, 50, n);
      `check(n, 50)
      trigger(1'b1);
    end
    wr(wwdrt_pkg::A_STAT, 8'h1f);
    // an early frame without the trigger qualifier must be ignored
    trig <= 1'b0;
    trigger(1'b0);
    trig <= 1'b1;
    wait_lvl(0, 1'b0, 200, n);
    `check(n inside {[70:74]}, 1'b1)
    rd(wwdrt_pkg::A_STAT, 8'h02);
    wait_lvl(0, 1'b1, 100, n);
    wr(wwdrt_pkg::A_WDCTL, 8'h39);
    wait_lvl(0, 1'b0, 50, n);
    `check(n, 50)
    trigger(1'b0);
    wait_lvl(0, 1'b0, 10, n);
    `check(n < 10, 1'b1)
    wait_lvl(0, 1'b1, 100, n);
    wr(wwdrt_pkg::A_WDCTL, 8'h07);
    wr(wwdrt_pkg::A_CMD, 8'h02);
    wr(wwdrt_pkg::A_STAT, 8'h1f);
    ext_rst_n_i <= 1'b0;
    wait_lvl(0, 1'b0, 10, n);
    ext_rst_n_i <= 1'b1;
    `check(n, 10)
    repeat (5) tick();
    ext_rst_n_i <= 1'b0;
    wait_lvl(0, 1'b0, 40, n);
    ext_rst_n_i <= 1'b1;
    `check(n inside {[17:23]}, 1'b1)
    wait_lvl(0, 1'b1, 300, n);
    rd(wwdrt_pkg::A_STAT, 8'h04);
    wr(wwdrt_pkg::A_STAT, 8'h1f);
    wake_i <= 1'b1;
    repeat (30) tick();
    wake_i <= 1'b0;
    rd(wwdrt_pkg::A_STAT, 8'h00);
    wake_i <= 1'b1;
    repeat (60) tick();
    wake_i <= 1'b0;
    rd(wwdrt_pkg::A_STAT, 8'h08);
    wr(wwdrt_pkg::A_MODE, 8'h07);
    wait_lvl(2, 1'b1, 400, n);
    `check(n inside {[316:320]}, 1'b1)
    wr(wwdrt_pkg::A_MODE, 8'h00);
    wait_lvl(2, 1'b0, 3, n);
    `check(n < 3, 1'b1)
    wr(wwdrt_pkg::A_STAT, 8'h1f);
    wr(wwdrt_pkg::A_CMD, 8'h01);
    rd(wwdrt_pkg::A_STATE, 8'h10);
    wait_lvl(4, 1'b1, 100, n);
    `check(n inside {[56:63]}, 1'b1)
    tick();
    `check(nv_restore_o, 1'b0)
    rd(wwdrt_pkg::A_STAT, 8'h10);
    wr(wwdrt_pkg::A_CRC, 8'h11);
    wait_lvl(3, 1'b1, 5, n);
    `check(n, 5)
    wr(wwdrt_pkg::A_CRC, 8'h5a);
    wait_lvl(3, 1'b1, 3, n);
    `check(n < 3, 1'b1)
    wait_lvl(3, 1'b0, 60, n);
    `check(n inside {[29:33]}, 1'b1)
    print_verdict();
  end
endmodule
`default_nettype wire
